//--- src/mrp_pkg.sv
`default_nettype none
package mrp_pkg;
   localparam int unsigned NUM_REGIONS = 8;
   localparam int unsigned NUM_SUBREG  = 8;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS     = 8'h00;
   localparam logic [7:0] TYPE_OFS     = 8'h04;
   localparam logic [7:0] SEL_OFS      = 8'h08;
   localparam logic [7:0] BASE_OFS     = 8'h0c;
   localparam logic [7:0] ATTR_OFS     = 8'h10;
   localparam logic [7:0] STAT_OFS     = 8'h14;
   localparam logic [7:0] CLR_OFS      = 8'h18;
   localparam logic [7:0] IEN_OFS      = 8'h1c;
   localparam logic [7:0] FADDR_OFS    = 8'h20;
   // control fields
   localparam int unsigned CTRL_EN_BIT   = 0;
   localparam int unsigned CTRL_HFNMI_BIT = 1;
   localparam int unsigned CTRL_PRIV_BIT = 2;
   localparam int unsigned CTRL_FEN_BIT  = 3;
   // attribute fields
   localparam int unsigned ATTR_EN_BIT   = 0;
   localparam int unsigned ATTR_SZ_LSB   = 1;
   localparam int unsigned ATTR_SRD_LSB  = 8;
   localparam int unsigned ATTR_AP_LSB   = 24;
   localparam int unsigned ATTR_XN_BIT   = 28;
   localparam logic [4:0]  SZ_MIN        = 5'h04;
   localparam logic [4:0]  SZ_SUB_MIN    = 5'h07;
   localparam logic [4:0]  SZ_MAX        = 5'h1f;
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
   localparam logic [31:0] ATTR_RESET    = 32'h0000_0008;
   // status bits
   localparam int unsigned ST_FAULT_BIT  = 0;
   localparam int unsigned ST_NOREG_BIT  = 1;
   // axi responses
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   // data access permission codes
   localparam logic [2:0] AP_NO_NO = 3'h0;
   localparam logic [2:0] AP_RW_NO = 3'h1;
   localparam logic [2:0] AP_RW_RO = 3'h2;
   localparam logic [2:0] AP_RW_RW = 3'h3;
   localparam logic [2:0] AP_RO_NO = 3'h5;
   localparam logic [2:0] AP_RO_RO = 3'h6;
endpackage : mrp_pkg
`default_nettype wire

//--- src/mrp_unit.sv
// Overview of operation
// R1 - eight regions, each with its own base address and size
// R2 - region size is a power of two from 32 bytes to 4 GB
// R3 - software aligns each base to its region size
// R4 - fetch from a non-executable region is a violation
// R5 - no, read-only or read/write access per privileged and user mode
// R6 - eight equal sub-regions per region, each with a disable bit
// R7 - sub-region disables act only in regions of 256 bytes or more
// R8 - violation while enabled raises a memory management fault
// R9 - region enable bit clears without losing base, size or attributes
// R10 - attribute read-back holds the enable bit, rewritable as is
// R11 - privileged default map covers privileged misses when option set
// R12 - option clear: fault if enabled with no region configured and enabled
// R13 - fault-handler option keeps checking in hard-fault and NMI handlers
// R14 - globally disabled: default map, no fault
// R15 - software sets a region or the default option before enabling
// R16 - software disables a region before rewriting it
// R17 - fault exception has its own enable gating the handler
// R18 - number of supported regions is readable
// R19 - highest matching region wins; check completes in the access cycle
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`default_nettype none
module mrp_unit
   import mrp_pkg::*;
(
   input  wire logic        aclk,          // core clock
   input  wire logic        aresetn,       // sync reset, active low
   input  wire logic [7:0]  s_axi_awaddr,  // write address
   input  wire logic        s_axi_awvalid, // write address valid
   output logic             s_axi_awready, // write address ready
   input  wire logic [31:0] s_axi_wdata,   // write data
   input  wire logic [3:0]  s_axi_wstrb,   // write strobes
   input  wire logic        s_axi_wvalid,  // write data valid
   output logic             s_axi_wready,  // write data ready
   output logic [1:0]       s_axi_bresp,   // write response
   output logic             s_axi_bvalid,  // write response valid
   input  wire logic        s_axi_bready,  // write response ready
   input  wire logic [7:0]  s_axi_araddr,  // read address
   input  wire logic        s_axi_arvalid, // read address valid
   output logic             s_axi_arready, // read address ready
   output logic [31:0]      s_axi_rdata,   // read data
   output logic [1:0]       s_axi_rresp,   // read response
   output logic             s_axi_rvalid,  // read data valid
   input  wire logic        s_axi_rready,  // read data ready
   input  wire logic        acc_valid,     // core access this cycle
   input  wire logic [31:0] acc_addr,      // access address
   input  wire logic        acc_fetch,     // instruction fetch
   input  wire logic        acc_write,     // data write
   input  wire logic        acc_priv,      // privileged mode
   input  wire logic        acc_hf_nmi,    // in hard-fault or nmi handler
   output logic             acc_deny,      // access refused (comb)
   output logic             mm_fault,      // fault to core, registered
   output logic             irq            // level interrupt
);
   default clocking cb_acc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [2:0] {
      W_IDLE = 3'b001,
      W_RESP = 3'b010,
      W_HOLD = 3'b100
   } mrp_wst_t;

   logic [31:0] ctrl;
   logic [2:0]  sel;
   logic [31:0] base_r [NUM_REGIONS]; // see R1
   logic [31:0] attr_r [NUM_REGIONS];
   logic [1:0]  stat;
   logic [1:0]  ien;
   logic [31:0] faddr;
   logic        have_aw, have_w;
   logic [7:0]  aw_q;
   logic [31:0] w_q;
   logic [3:0]  ws_q;
   mrp_wst_t    wst;

   // byte-lane merge, used for the ctrl, base and attribute registers
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   ////////////////////////////////////////////////////////////////////////
   // access checking, purely combinational within the access cycle
   wire         glob_en  = ctrl[CTRL_EN_BIT];
   wire         opt_priv = ctrl[CTRL_PRIV_BIT];
   wire         opt_hf   = ctrl[CTRL_HFNMI_BIT];
   logic [NUM_REGIONS-1:0] hit;
   logic [NUM_REGIONS-1:0] live;

   genvar g;
   generate
      for (g = 0; g < NUM_REGIONS; g++) begin : g_rgn
         wire [4:0]  sz   = attr_r[g][ATTR_SZ_LSB +: 5];
         // region spans 2^(sz+1) bytes
         wire [31:0] mask = (sz >= SZ_MAX) ? 32'hffff_ffff
                          : ((32'h0000_0002 << sz) - 32'h0000_0001);
         wire        inreg = ((acc_addr & ~mask) == (base_r[g] & ~mask));
         wire [31:0] off   = acc_addr & mask;
         wire [2:0]  sub   = (sz >= SZ_MAX) ? acc_addr[31:29]
                           : 3'(off >> (sz - 5'h02));
         wire        sdis  = (sz >= SZ_SUB_MIN) && // see R7
                             attr_r[g][ATTR_SRD_LSB + sub]; // see R6
         assign live[g] = attr_r[g][ATTR_EN_BIT] && (sz >= SZ_MIN); // see R2
         assign hit[g]  = live[g] && inreg && !sdis; // see R9
      end
   endgenerate

   logic [31:0] win_attr;
   always_comb begin
      win_attr = '0;
      for (int i = 0; i < NUM_REGIONS; i++) begin
         if (hit[i]) begin
            win_attr = attr_r[i]; // see R19
         end
      end
   end

   wire [2:0] ap = win_attr[ATTR_AP_LSB +: 3];
   logic perm_ok;
   always_comb begin
      unique case (ap)
         AP_RW_NO: perm_ok = acc_priv;
         AP_RW_RO: perm_ok = acc_priv || !acc_write;
         AP_RW_RW: perm_ok = 1'b1;
         AP_RO_NO: perm_ok = acc_priv && !acc_write;
         AP_RO_RO: perm_ok = !acc_write;
         default:  perm_ok = 1'b0; // see R5
      endcase
   end

   wire any_hit  = |hit;
   wire checking = glob_en && (opt_hf || !acc_hf_nmi); // see R13 R14
   wire dflt_ok  = opt_priv && acc_priv; // see R11
   wire no_live  = ~|live;
   wire hit_bad  = (acc_fetch && win_attr[ATTR_XN_BIT]) || // see R4
                   (!acc_fetch && !perm_ok);
   assign acc_deny = acc_valid && checking &&
                     (any_hit ? hit_bad : !dflt_ok); // see R8 R12
   wire fen = ctrl[CTRL_FEN_BIT];
   wire noreg_ev = acc_valid && checking && no_live && !opt_priv; // see R12

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite write side: address and data taken in either order
   assign s_axi_awready = (wst == W_IDLE) && !have_aw;
   assign s_axi_wready  = (wst == W_IDLE) && !have_w;
   wire aw_t = s_axi_awvalid && s_axi_awready;
   wire w_t  = s_axi_wvalid && s_axi_wready;
   wire do_wr = (wst == W_HOLD);
   wire wr_ok = (aw_q <= FADDR_OFS) && (aw_q[1:0] == 2'h0) &&
                (aw_q != TYPE_OFS) && (aw_q != STAT_OFS) &&
                (aw_q != FADDR_OFS);
   wire clr_wr = do_wr && (aw_q == CLR_OFS);
   logic [1:0] clr_bits;
   assign clr_bits = clr_wr ? w_q[1:0] : 2'h0;
   wire [1:0] ev = {noreg_ev, acc_deny};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wst <= W_IDLE;
         have_aw <= 1'b0;
         have_w <= 1'b0;
         aw_q <= 8'h00;
         w_q <= 32'h0000_0000;
         ws_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         unique case (wst)
            W_IDLE: begin
               if (aw_t) begin
                  have_aw <= 1'b1;
                  aw_q <= s_axi_awaddr;
               end
               if (w_t) begin
                  have_w <= 1'b1;
                  w_q <= s_axi_wdata;
                  ws_q <= s_axi_wstrb;
               end
               if ((have_aw || aw_t) && (have_w || w_t)) begin
                  wst <= W_HOLD;
               end
            end
            W_HOLD: begin
               wst <= W_RESP;
               s_axi_bvalid <= 1'b1;
               s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            W_RESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  have_aw <= 1'b0;
                  have_w <= 1'b0;
                  wst <= W_IDLE;
               end
            end
         endcase
      end
   end

   // register storage; a region keeps everything when only its enable drops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= CTRL_RESET;
         sel <= 3'h0;
         ien <= 2'h0;
         for (int i = 0; i < NUM_REGIONS; i++) begin
            base_r[i] <= 32'h0000_0000;
            attr_r[i] <= ATTR_RESET;
         end
      end else if (do_wr) begin
         unique case (aw_q)
            CTRL_OFS: ctrl <= merge(ctrl, w_q, ws_q) & 32'h0000_000f;
            SEL_OFS:  sel <= ws_q[0] ? w_q[2:0] : sel;
            BASE_OFS: base_r[sel] <= merge(base_r[sel], w_q, ws_q)
                                     & 32'hffff_ffe0; // see R3
            ATTR_OFS: attr_r[sel] <= merge(attr_r[sel], w_q, ws_q); // see R9
            IEN_OFS:  ien <= ws_q[0] ? w_q[1:0] : ien;
            default: ;
         endcase
      end
   end

   // sticky status: a new event wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat <= 2'h0;
         faddr <= 32'h0000_0000;
         mm_fault <= 1'b0;
      end else begin
         stat <= (stat & ~clr_bits) | ev;
         if (acc_deny) begin
            faddr <= acc_addr;
         end
         mm_fault <= acc_deny && fen; // see R8 R17
      end
   end
   assign irq = |(stat & ien);

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite read side
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (s_axi_araddr == CTRL_OFS) rd_mux = ctrl;
      if (s_axi_araddr == TYPE_OFS) rd_mux = 32'(NUM_REGIONS); // see R18
      if (s_axi_araddr == SEL_OFS)  rd_mux = {29'h0, sel};
      if (s_axi_araddr == BASE_OFS) rd_mux = base_r[sel];
      if (s_axi_araddr == ATTR_OFS) rd_mux = attr_r[sel]; // see R10
      if (s_axi_araddr == STAT_OFS) rd_mux = {30'h0, stat};
      if (s_axi_araddr == IEN_OFS)  rd_mux = {30'h0, ien};
      if (s_axi_araddr == FADDR_OFS) rd_mux = faddr;
   end
   wire rd_ok = (s_axi_araddr <= FADDR_OFS) && (s_axi_araddr[1:0] == 2'h0)
                && (s_axi_araddr != CLR_OFS);
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_ok ? rd_mux : 32'h0000_0000;
         s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   sequence s_denied;
      acc_deny && fen;
   endsequence
   sequence s_noreg_access;
      acc_valid && glob_en && !acc_hf_nmi && no_live && !opt_priv;
   endsequence
   sequence s_deny_then_noreg;
      acc_deny ##1 stat[ST_NOREG_BIT];
   endsequence

   a_fault_follows: assert property (s_denied |=> mm_fault) // see R8
      else $error("deny with fault enabled gave no fault");
   a_fault_gated: assert property (!fen |=> !mm_fault) // see R17
      else $error("fault raised with exception disabled");
   a_off_no_deny: assert property (!glob_en |-> !acc_deny) // see R14
      else $error("deny while protection off");
   a_hf_bypass: assert property ( // see R13
      (acc_hf_nmi && !opt_hf) |-> !acc_deny)
      else $error("deny in handler without option");
   a_priv_dflt: assert property ( // see R11
      (!any_hit && opt_priv && acc_priv) |-> !acc_deny)
      else $error("privileged miss denied with default map");
   a_noreg_fault: assert property ( // see R12
      s_noreg_access |-> s_deny_then_noreg)
      else $error("no region enabled did not fault");
   a_xn_fetch: assert property ( // see R4
      (acc_valid && checking && any_hit && acc_fetch && win_attr[ATTR_XN_BIT])
      |-> acc_deny)
      else $error("fetch from non-executable region allowed");
   a_user_ro: assert property ( // see R5
      (acc_valid && checking && any_hit && !acc_fetch && acc_write
       && ap == AP_RO_RO) |-> acc_deny)
      else $error("write to read-only region allowed");
   a_count_read: assert property ( // see R18
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == TYPE_OFS)
      |=> s_axi_rdata == 32'h0000_0008)
      else $error("region count read wrong");
endmodule : mrp_unit
`default_nettype wire

//--- testbench/mrp_core_model.sv
`default_nettype none
module mrp_core_model (
   input  wire logic        aclk,       // core clock
   input  wire logic        acc_deny,   // verdict from the unit
   output logic             acc_valid,  // access strobe
   output logic [31:0]      acc_addr,   // access address
   output logic             acc_fetch,  // instruction fetch
   output logic             acc_write,  // data write
   output logic             acc_priv,   // privileged mode
   output logic             acc_hf_nmi  // in fault handler
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      acc_valid = 1'b0;
      acc_addr = 32'h0000_0000;
      {acc_hf_nmi, acc_priv, acc_write, acc_fetch} = 4'h0;
   end
   // one access per call, held one cycle; k = {hf_nmi, priv, write, fetch}
   task automatic issue(input logic [31:0] a, input logic [3:0] k,
                        output logic d);
      @(posedge aclk);
      acc_valid <= 1'b1;
      acc_addr <= a;
      {acc_hf_nmi, acc_priv, acc_write, acc_fetch} <= k;
      #2 d = acc_deny;
      @(posedge aclk);
      acc_valid <= 1'b0;
      // idle address flipped so a stale value cannot look like a match
      acc_addr <= ~a;
      {acc_hf_nmi, acc_priv, acc_write, acc_fetch} <= ~k;
   endtask : issue
endmodule : mrp_core_model
`default_nettype wire

//--- testbench/tb.sv
`default_nettype none
module tb
   import mrp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [3:0]  ctrl;
      logic [31:0] addr;
      logic [3:0]  k;
      logic        deny;
   } mrp_row_t;
   logic        aclk, aresetn, awready, wready, bvalid, arready, rvalid;
   logic        awvalid, wvalid, bready, arvalid, rready, irq, mm_fault;
   logic        acc_valid, acc_fetch, acc_write, acc_priv, acc_hf_nmi;
   logic        acc_deny, d;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rdat, acc_addr, v;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, resp;
   int          errors, n_compared, cyc;
   mrp_row_t    rows[17] = '{
      '{4'hd, 32'h0000_0100, 4'h0, 1'b0},
      '{4'hd, 32'h0000_0100, 4'h2, 1'b1},
      '{4'hd, 32'h0000_0100, 4'h1, 1'b0},
      '{4'hd, 32'h0000_7100, 4'h0, 1'b1},
      '{4'hd, 32'h0000_7100, 4'h4, 1'b0},
      '{4'hd, 32'h2000_0400, 4'h5, 1'b1},
      '{4'hd, 32'h2000_0400, 4'h2, 1'b0},
      '{4'hd, 32'h2000_0010, 4'h2, 1'b1},
      '{4'hd, 32'h2000_0010, 4'h6, 1'b0},
      '{4'hd, 32'h4000_0010, 4'h0, 1'b0},
      '{4'hd, 32'h5000_0000, 4'h0, 1'b1},
      '{4'hd, 32'h5000_0020, 4'h0, 1'b0},
      '{4'h0, 32'h2000_0010, 4'h2, 1'b0},
      '{4'h9, 32'h6000_0000, 4'h4, 1'b1},
      '{4'h9, 32'h2000_0010, 4'ha, 1'b0},
      '{4'hb, 32'h2000_0010, 4'ha, 1'b1},
      '{4'h5, 32'h0000_0100, 4'h2, 1'b1}};
   mrp_unit i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .acc_valid(acc_valid),
      .acc_addr(acc_addr), .acc_fetch(acc_fetch), .acc_write(acc_write),
      .acc_priv(acc_priv), .acc_hf_nmi(acc_hf_nmi), .acc_deny(acc_deny),
      .mm_fault(mm_fault), .irq(irq));
   mrp_core_model i_core (.aclk(aclk), .acc_deny(acc_deny),
      .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_fetch(acc_fetch),
      .acc_write(acc_write), .acc_priv(acc_priv), .acc_hf_nmi(acc_hf_nmi));
   always #2.5 aclk = ~aclk;
   ////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : summarize
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask : check
   // waits have no own limit: the cycle ceiling below ends a hang
   task automatic wr(input logic [7:0] a, input logic [31:0] dat);
      @(posedge aclk);
      awaddr <= a;
      wdata <= dat;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid) begin
            resp = bresp;
            bready <= 1'b0;
            return;
         end
      end
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid) begin
            rdat = rdata;
            resp = rresp;
            rready <= 1'b0;
            return;
         end
      end
   endtask : rd
   function automatic logic [31:0] att(input logic [4:0] code,
      input logic [7:0] srd, input logic [2:0] ap, input logic xn);
      return {3'h0, xn, 1'b0, ap, 8'h00, srd, 2'h0, code, 1'b1};
   endfunction : att
   // attributes go last so a region only goes live once base is set
   task automatic rgn(input logic [2:0] n, input logic [31:0] base,
                      input logic [31:0] at);
      wr(SEL_OFS, {29'h0, n});
      wr(BASE_OFS, base);
      wr(ATTR_OFS, at);
   endtask : rgn
   task automatic acc(input logic [31:0] a, input logic [3:0] k,
                      input logic exp);
      i_core.issue(a, k, d);
      check({31'h0, d}, {31'h0, exp});
   endtask : acc
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         errors++;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
      {awaddr, araddr, wdata} = 48'h0;
      wstrb = 4'hf;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(CTRL_OFS);
      check(rdat, CTRL_RESET);
      rd(TYPE_OFS);
      check(rdat, 32'h0000_0008);
      rd(ATTR_OFS);
      check(rdat, ATTR_RESET);
      rgn(3'h0, 32'h0000_0000, att(5'h0e, 8'h80, AP_RO_RO, 1'b0));
      rgn(3'h1, 32'h2000_0000, att(5'h0e, 8'h00, AP_RW_RW, 1'b1));
      rgn(3'h2, 32'h2000_0000, att(5'h07, 8'h00, AP_RW_NO, 1'b1));
      rgn(3'h3, 32'h4000_0000, att(5'h06, 8'hff, AP_RW_RW, 1'b0));
      rgn(3'h4, 32'h5000_0000, att(5'h07, 8'h01, AP_RW_RW, 1'b0));
      foreach (rows[i]) begin
         wr(CTRL_OFS, {28'h0, rows[i].ctrl});
         acc(rows[i].addr, rows[i].k, rows[i].deny);
         v = {31'h0, rows[i].deny & rows[i].ctrl[3]};
         #1 check({31'h0, mm_fault}, v);
      end
      // smallest region in the last slot
      rgn(3'h7, 32'h6000_0000, att(SZ_MIN, 8'h00, AP_RW_RW, 1'b0));
      wr(CTRL_OFS, 32'h0000_000d);
      acc(32'h6000_001f, 4'h0, 1'b0);
      acc(32'h6000_0020, 4'h0, 1'b1);
      rd(BASE_OFS);
      check(rdat, 32'h6000_0000);
      wr(SEL_OFS, 32'h0000_0001);
      rd(ATTR_OFS);
      v = rdat;
      check(v, att(5'h0e, 8'h00, AP_RW_RW, 1'b1));
      wr(ATTR_OFS, v & 32'hffff_fffe);
      acc(32'h2000_0400, 4'h2, 1'b1);
      wr(ATTR_OFS, v);
      acc(32'h2000_0400, 4'h2, 1'b0);
      wr(IEN_OFS, 32'h0000_0001);
      check({31'h0, irq}, 32'h1);
      wr(IEN_OFS, 32'h0000_0000);
      check({31'h0, irq}, 32'h0);
      wr(IEN_OFS, 32'h0000_0001);
      wr(CLR_OFS, 32'h0000_0001);
      rd(STAT_OFS);
      check(rdat, 32'h0000_0000);
      check({31'h0, irq}, 32'h0);
      rd(8'h24);
      check({30'h0, resp}, {30'h0, RESP_SLVERR});
      wr(TYPE_OFS, 32'h0000_0003);
      check({30'h0, resp}, {30'h0, RESP_SLVERR});
      rd(TYPE_OFS);
      check(rdat, 32'h0000_0008);
      // reset again mid-run: region 0 (sel resets to 0) must come back disabled
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(ATTR_OFS);
      check(rdat, ATTR_RESET);
      rd(STAT_OFS);
      check(rdat, 32'h0000_0000);
      // enabled with no live region and no default map: even priv denied
      wr(CTRL_OFS, 32'h0000_0009);
      acc(32'h0000_0100, 4'h4, 1'b1);
      #1 check({31'h0, mm_fault}, 32'h1);
      rd(STAT_OFS);
      check(rdat, 32'h0000_0003);
      rd(FADDR_OFS);
      check(rdat, 32'h0000_0100);
      summarize();
   end
endmodule : tb
`default_nettype wire
